// ---- shared/tsa_pkg.sv ----
// Package: map, fields, defaults and timing of the setpoint/alarm block
package tsa_pkg;
	// Register byte offsets
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_TARGET = 8'h04;
	localparam logic [7:0] A_COMF   = 8'h08;
	localparam logic [7:0] A_STBY   = 8'h0C;
	localparam logic [7:0] A_ECON   = 8'h10;
	localparam logic [7:0] A_PROT   = 8'h14;
	localparam logic [7:0] A_MODE   = 8'h18;
	localparam logic [7:0] A_AUX    = 8'h1C;
	localparam logic [7:0] A_WEIGHT = 8'h20;
	localparam logic [7:0] A_CYCLE  = 8'h24;
	localparam logic [7:0] A_STAT   = 8'h28;
	localparam logic [7:0] A_ISTAT  = 8'h2C;
	localparam logic [7:0] A_IMASK  = 8'h30;
	localparam logic [7:0] A_TEFF   = 8'h34;
	// Control register fields
	localparam int C_SCHEME = 0;
	localparam int C_COOL   = 2;
	localparam int C_WIN_EN = 3;
	localparam int C_WGT_EN = 4;
	localparam int C_CHAN   = 5;
	localparam int C_NTC    = 7;
	localparam int C_LOCK   = 11;
	localparam int CTRL_W   = 12;
	localparam logic [11:0] CTRL_RST = 12'h780;
	// Setpoint schemes
	localparam logic [1:0] SCH_SINGLE = 2'h0;
	localparam logic [1:0] SCH_REL    = 2'h1;
	localparam logic [1:0] SCH_ABS    = 2'h2;
	// Operating mode request codes
	localparam logic [7:0] MC_COMF = 8'h01;
	localparam logic [7:0] MC_STBY = 8'h02;
	localparam logic [7:0] MC_ECON = 8'h03;
	localparam logic [7:0] MC_PROT = 8'h04;
	typedef enum logic [1:0]
	{
		TSA_COMFORT,
		TSA_STANDBY,
		TSA_ECONOMY,
		TSA_PROTECT
	} tsa_mode_t;
	// Temperatures in hundredths of a degree, signed
	localparam logic [15:0] DEF_HEAT      = 16'h0834;
	localparam logic [15:0] DEF_COOL      = 16'h0960;
	localparam logic [15:0] DEF_PROT_HEAT = 16'h02BC;
	localparam logic [15:0] DEF_PROT_COOL = 16'h0DAC;
	localparam logic [15:0] DEF_STBY      = 16'h00C8;
	localparam logic [15:0] DEF_ECON      = 16'h015E;
	// Sensor plausibility limits
	localparam logic [15:0] T_LOW    = 16'hF830;
	localparam logic [15:0] T_HIGH   = 16'h1B58;
	localparam logic [15:0] OHM_LOW  = 16'h0100;
	localparam logic [15:0] OHM_HIGH = 16'hF000;
	// Weighting: weight of local reading out of W_FULL
	localparam logic [4:0] W_FULL   = 5'h10;
	localparam logic [4:0] DEF_WGT  = 5'h08;
	// Modulation cycle in minutes
	localparam logic [7:0] DEF_CYCLE = 8'h0F;
	// Timing
	localparam longint CLK_HZ        = 250000000;
	localparam longint AUX_TIMEOUT_S = 600;
	localparam logic [39:0] AUX_TIMEOUT_CYC =
		40'(AUX_TIMEOUT_S * CLK_HZ);
	// Interrupt status bits
	localparam int I_ALARM = 0;
	localparam int I_CLEAR = 1;
	localparam int I_WIN   = 2;
	localparam int I_MODE  = 3;
	localparam int IRQ_W   = 4;
	// Non-volatile store word indices
	localparam logic [2:0] NV_TARGET = 3'h0;
	localparam logic [2:0] NV_COMF   = 3'h1;
	localparam logic [2:0] NV_STBY   = 3'h2;
	localparam logic [2:0] NV_ECON   = 3'h3;
	localparam logic [2:0] NV_PROT   = 3'h4;
endpackage

// ---- logic/tsa_setsel.sv ----
// Setpoint selector: scheme, mode and direction to working setpoint
`timescale 1ns/1ps
`default_nettype none
module tsa_setsel
(
	// Configuration
	input  wire logic [1:0]         scheme,
	input  wire logic               cool,
	input  wire tsa_pkg::tsa_mode_t mode,
	// Stored objects
	input  wire logic [15:0]        target,
	input  wire logic               target_rx,
	input  wire logic [15:0]        comfort,
	input  wire logic               comfort_rx,
	input  wire logic [15:0]        standby,
	input  wire logic [15:0]        economy,
	input  wire logic [31:0]        prot,
	// Result
	output logic [15:0]             setpoint
);
	import tsa_pkg::*;

	// Attenuation: cooling raises, heating lowers
	function automatic logic [15:0] atten(input logic [15:0] base,
		input logic [15:0] ofs, input logic c);
		atten = c ? 16'(base + ofs) : 16'(base - ofs);
	endfunction

	wire [15:0] dflt     = cool ? DEF_COOL : DEF_HEAT;
	wire [15:0] prot_sel = cool ? prot[31:16] : prot[15:0];
	wire [15:0] comf_eff = comfort_rx ? comfort : dflt;
	// Single: target or protection level only
	wire [15:0] single_sp = (mode == TSA_PROTECT) ? prot_sel :
		(target_rx ? target : dflt);
	// Relative: derived from comfort
	wire [15:0] rel_sp =
		(mode == TSA_STANDBY) ? atten(comf_eff, standby, cool) :
		(mode == TSA_ECONOMY) ? atten(comf_eff, economy, cool) :
		(mode == TSA_PROTECT) ? prot_sel : comf_eff;
	// Absolute: each mode its own value
	wire [15:0] abs_sp =
		(mode == TSA_STANDBY) ? standby :
		(mode == TSA_ECONOMY) ? economy :
		(mode == TSA_PROTECT) ? prot_sel : comf_eff;

	assign setpoint = (scheme == SCH_REL) ? rel_sp :
		(scheme == SCH_ABS) ? abs_sp : single_sp;
endmodule
`default_nettype wire

// ---- logic/tsa_wmean.sv ----
// Weighted mean of local and bus-received temperature
`timescale 1ns/1ps
`default_nettype none
module tsa_wmean
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// Inputs
	input  wire logic        enable,
	input  wire logic [4:0]  weight,
	input  wire logic [15:0] local_temp,
	input  wire logic [15:0] aux_temp,
	// Result
	output logic [15:0]      temp_eff
);
	import tsa_pkg::*;

	// Weight is clipped so a bad write cannot go negative
	wire [4:0] w_loc = (weight > W_FULL) ? W_FULL : weight;
	wire [4:0] w_aux = 5'(W_FULL - w_loc);
	wire signed [22:0] p_loc =
		23'($signed(local_temp) * $signed({1'b0, w_loc}));
	wire signed [22:0] p_aux =
		23'($signed(aux_temp) * $signed({1'b0, w_aux}));
	wire signed [22:0] sum = 23'(p_loc + p_aux);

	// Registered mean, or local reading alone
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			temp_eff <= 16'h0000;
		else
			temp_eff <= enable ? sum[19:4] : local_temp;
	end
endmodule
`default_nettype wire

// ---- logic/tsa_top.sv ----
// Thermostat setpoint selection and control alarm, AHB-Lite slave
// Function
// - One writable target, periodic or on-change
// - Target kept in non-volatile store in single scheme
// - Unreceived target uses heat/cool defaults
// - Open window: freeze target, use protection
// - Relative scheme exposes four writable objects
// - Standby/economy derived from comfort
// - Relative objects kept in non-volatile store
// - Mode from request, comfort until received
// - Single scheme: target and protection levels
// - Four exclusive modes in relative/absolute
// - Halt on lock, sensor fault, aux timeout
// - Halted: command zero, alarm object set
// - Room probe from thermistor-typed channel
// - Optional weighted mean with bus temperature
// - Modulation cycle about fifteen-twenty minutes
`timescale 1ns/1ps
`default_nettype none
module tsa_top
#(
	parameter logic [39:0] AUX_TIMEOUT_CYC = tsa_pkg::AUX_TIMEOUT_CYC
)
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Window contact pins, asynchronous
	input  wire logic        window_a,
	input  wire logic        window_b,
	// Thermistor channels, four of 16 bits each
	input  wire logic [63:0] probe_temp,
	input  wire logic [63:0] probe_ohms,
	// Demand from the control algorithm, percent
	input  wire logic [7:0]  ctrl_demand,
	// Towards the control algorithm and valve
	output logic [7:0]       cmd_out,
	output logic             ctrl_halt,
	output logic             ctrl_restart,
	output logic             ctrl_cool,
	output logic [15:0]      setpoint_out,
	output logic [15:0]      temp_eff,
	output logic [7:0]       cycle_minutes,
	// Alarm object and interrupt
	output logic             temp_alarm,
	output logic             irq,
	// Non-volatile store
	output logic             nv_store,
	output logic [2:0]       nv_idx,
	output logic [31:0]      nv_data,
	input  wire logic        nv_load,
	input  wire logic [2:0]  nv_load_idx,
	input  wire logic [31:0] nv_load_data
);
	import tsa_pkg::*;

	// Valid operating mode request code
	function automatic logic mode_ok(input logic [7:0] c);
		mode_ok = (c >= MC_COMF) && (c <= MC_PROT);
	endfunction

	// Reading and resistance disagree (thermistor falls with heat)
	function automatic logic implausible(input logic [15:0] t,
		input logic [15:0] r);
		implausible = ($signed(t) < $signed(T_LOW) && r < OHM_LOW) ||
			($signed(t) > $signed(T_HIGH) && r > OHM_HIGH);
	endfunction

	// Stored objects
	logic [CTRL_W-1:0] ctrl;         // Control bits
	logic [15:0]       target;       // Single target
	logic [15:0]       comfort;      // Comfort setpoint
	logic [15:0]       short_absence_attenuation; // Standby
	logic [15:0]       economy;      // Economy offset/value
	logic [31:0]       prot;         // Protection cool:heat
	tsa_mode_t         mode;         // Requested mode
	logic [15:0]       aux;          // Bus temperature
	logic [4:0]        weight;       // Local weight
	logic [IRQ_W-1:0]  irq_stat;     // Sticky events
	logic [IRQ_W-1:0]  irq_mask;     // Event enables
	logic              target_rx;    // Target received
	logic              comfort_rx;   // Comfort received
	logic              mode_rx;      // Mode received
	// Bus data phase
	logic              dp_wr;        // Write pending
	logic [7:0]        dp_addr;      // Its offset
	// Window synchroniser and state
	logic [1:0]        win_s1;       // First stage only
	logic [1:0]        win_s2;       // Second stage
	logic              win_q;        // Window open
	// Timeout counter for the bus temperature
	logic [39:0]       aux_cnt;

	// Address phase decode
	wire ap_take = hsel && htrans[1] && hready;
	wire ap_hit  = (haddr[31:8] == 24'h000000);
	wire rd_take = ap_take && !hwrite && ap_hit;
	wire rd_irq  = rd_take && (haddr[7:0] == A_ISTAT);

	// Data phase write strobes
	wire wr_ctrl   = dp_wr && (dp_addr == A_CTRL);
	wire wr_target = dp_wr && (dp_addr == A_TARGET);
	wire wr_comf   = dp_wr && (dp_addr == A_COMF);
	wire wr_stby   = dp_wr && (dp_addr == A_STBY);
	wire wr_econ   = dp_wr && (dp_addr == A_ECON);
	wire wr_prot   = dp_wr && (dp_addr == A_PROT);
	wire wr_mode   = dp_wr && (dp_addr == A_MODE);
	wire wr_aux    = dp_wr && (dp_addr == A_AUX);
	wire wr_weight = dp_wr && (dp_addr == A_WEIGHT);
	wire wr_cycle  = dp_wr && (dp_addr == A_CYCLE);
	wire wr_imask  = dp_wr && (dp_addr == A_IMASK);

	// Configuration fields
	wire [1:0] scheme  = ctrl[C_SCHEME +: 2];
	wire       lock_in = ctrl[C_LOCK];
	wire       wgt_en  = ctrl[C_WGT_EN];
	wire [1:0] chan    = ctrl[C_CHAN +: 2];

	// Target frozen while the window is open
	wire tgt_take = wr_target && !win_q;
	// Mode request accepted only for a known code
	wire mode_take = wr_mode && mode_ok(hwdata[7:0]);
	// Loads from the non-volatile store on power-up
	wire ld_tgt  = nv_load && (nv_load_idx == NV_TARGET);
	wire ld_comf = nv_load && (nv_load_idx == NV_COMF);
	wire ld_stby = nv_load && (nv_load_idx == NV_STBY);
	wire ld_econ = nv_load && (nv_load_idx == NV_ECON);
	wire ld_prot = nv_load && (nv_load_idx == NV_PROT);

	// Window overrides every requested mode
	wire tsa_mode_t act_mode = win_q ? TSA_PROTECT :
		(scheme == SCH_SINGLE) ? TSA_COMFORT : mode;

	// Room probe: selected channel, thermistor type only
	wire [15:0] sel_temp = probe_temp[{chan, 4'h0} +: 16];
	wire [15:0] sel_ohms = probe_ohms[{chan, 4'h0} +: 16];
	wire        ntc_ok   = ctrl[C_NTC + 32'(chan)];

	// Alarm causes
	wire fault  = !ntc_ok || implausible(sel_temp, sel_ohms);
	wire aux_to = wgt_en && (aux_cnt == AUX_TIMEOUT_CYC);
	wire alarm  = lock_in || fault || aux_to;

	// Events for the interrupt status
	wire [IRQ_W-1:0] ev;
	assign ev[I_ALARM] = alarm && !temp_alarm;
	assign ev[I_CLEAR] = !alarm && temp_alarm;
	assign ev[I_WIN]   = win_q != (ctrl[C_WIN_EN] && |win_s2);
	assign ev[I_MODE]  = mode_take;

	// Working setpoint
	wire [15:0] sel_set;
	tsa_setsel u_setsel
	(
		.scheme     (scheme),
		.cool       (ctrl[C_COOL]),
		.mode       (act_mode),
		.target     (target),
		.target_rx  (target_rx),
		.comfort    (comfort),
		.comfort_rx (comfort_rx),
		.standby    (short_absence_attenuation),
		.economy    (economy),
		.prot       (prot),
		.setpoint   (sel_set)
	);

	// Effective room temperature
	tsa_wmean u_wmean
	(
		.hclk       (hclk),
		.hresetn    (hresetn),
		.enable     (wgt_en),
		.weight     (weight),
		.local_temp (sel_temp),
		.aux_temp   (aux),
		.temp_eff   (temp_eff)
	);

	// Read mux; unmapped offsets read zero
	wire [31:0] status = {setpoint_out, 8'h00, target_rx, win_q,
		2'(act_mode), aux_to, fault, lock_in, temp_alarm};
	wire [7:0] ra = haddr[7:0];
	wire [31:0] rd_mux =
		(ra == A_CTRL)   ? {20'h00000, ctrl} :
		(ra == A_TARGET) ? {16'h0000, target} :
		(ra == A_COMF)   ? {16'h0000, comfort} :
		(ra == A_STBY)   ? {16'h0000, short_absence_attenuation} :
		(ra == A_ECON)   ? {16'h0000, economy} :
		(ra == A_PROT)   ? prot :
		(ra == A_MODE)   ? {30'h00000000, 2'(mode)} :
		(ra == A_AUX)    ? {16'h0000, aux} :
		(ra == A_WEIGHT) ? {27'h0000000, weight} :
		(ra == A_CYCLE)  ? {24'h000000, cycle_minutes} :
		(ra == A_STAT)   ? status :
		(ra == A_ISTAT)  ? {28'h0000000, irq_stat} :
		(ra == A_IMASK)  ? {28'h0000000, irq_mask} :
		(ra == A_TEFF)   ? {16'h0000, temp_eff} : 32'h00000000;

	// Zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign ctrl_halt = temp_alarm;
	// Direction follows the supervisor's bit
	assign ctrl_cool = ctrl[C_COOL];
	// Level interrupt while an unmasked event is pending
	assign irq = |(irq_stat & irq_mask);

	// Capture the address phase; only word writes are accepted
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_wr   <= 1'b0;
			dp_addr <= 8'h00;
		end
		else
		begin
			dp_wr   <= ap_take && hwrite && ap_hit && (hsize == 3'h2);
			dp_addr <= haddr[7:0];
		end
	end

	// Read data registered at the address phase edge
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h00000000;
		else if (rd_take)
			hrdata <= rd_mux;
	end

	// Control bits and plain configuration
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl          <= CTRL_RST;
			weight        <= DEF_WGT;
			cycle_minutes <= DEF_CYCLE;
			irq_mask      <= '0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl <= hwdata[CTRL_W-1:0];
			if (wr_weight)
				weight <= hwdata[4:0];
			if (wr_cycle)
				cycle_minutes <= hwdata[7:0];
			if (wr_imask)
				irq_mask <= hwdata[IRQ_W-1:0];
		end
	end

	// Single target; bus write wins over a store load
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			target    <= DEF_HEAT;
			target_rx <= 1'b0;
		end
		else if (tgt_take || ld_tgt)
		begin
			target    <= tgt_take ? hwdata[15:0] : nv_load_data[15:0];
			target_rx <= 1'b1;
		end
	end

	// The four mode objects, writable in every scheme
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			comfort    <= DEF_HEAT;
			comfort_rx <= 1'b0;
			short_absence_attenuation <= DEF_STBY;
			economy    <= DEF_ECON;
			prot       <= {DEF_PROT_COOL, DEF_PROT_HEAT};
		end
		else
		begin
			if (wr_comf || ld_comf)
			begin
				comfort <= wr_comf ? hwdata[15:0] : nv_load_data[15:0];
				comfort_rx <= 1'b1;
			end
			if (wr_stby || ld_stby)
				short_absence_attenuation <=
					wr_stby ? hwdata[15:0] : nv_load_data[15:0];
			if (wr_econ || ld_econ)
				economy <= wr_econ ? hwdata[15:0] : nv_load_data[15:0];
			if (wr_prot || ld_prot)
				prot <= wr_prot ? hwdata : nv_load_data;
		end
	end

	// Requested mode, comfort until one arrives
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mode    <= TSA_COMFORT;
			mode_rx <= 1'b0;
		end
		else if (mode_take)
		begin
			mode    <= tsa_mode_t'(2'(hwdata[7:0] - MC_COMF));
			mode_rx <= 1'b1;
		end
	end

	// Copy a bus-written target (single scheme) or relative object (relative scheme) to the store
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			nv_store <= 1'b0;
			nv_idx   <= NV_TARGET;
			nv_data  <= 32'h00000000;
		end
		else
		begin
			nv_store <= (tgt_take && scheme == SCH_SINGLE) ||
				((wr_comf || wr_stby || wr_econ || wr_prot) &&
				scheme == SCH_REL);
			nv_idx   <= wr_comf ? NV_COMF : wr_stby ? NV_STBY :
				wr_econ ? NV_ECON : wr_prot ? NV_PROT : NV_TARGET;
			nv_data  <= wr_prot ? hwdata : {16'h0000, hwdata[15:0]};
		end
	end

	// Bus temperature and its freshness counter
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			aux     <= 16'h0000;
			aux_cnt <= 40'h0000000000;
		end
		else if (wr_aux)
		begin
			aux     <= hwdata[15:0];
			aux_cnt <= 40'h0000000000;
		end
		else if (aux_cnt != AUX_TIMEOUT_CYC)
			aux_cnt <= 40'(aux_cnt + 40'h0000000001);
	end

	// Window pins pass two flip-flops before use
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			win_s1 <= 2'h0;
			win_s2 <= 2'h0;
			win_q  <= 1'b0;
		end
		else
		begin
			win_s1 <= {window_b, window_a};
			win_s2 <= win_s1;
			win_q  <= ctrl[C_WIN_EN] && |win_s2;
		end
	end

	// Alarm, command and restart; a setpoint change also restarts
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			temp_alarm   <= 1'b0;
			cmd_out      <= 8'h00;
			ctrl_restart <= 1'b0;
			setpoint_out <= DEF_HEAT;
		end
		else
		begin
			temp_alarm   <= alarm;
			cmd_out      <= alarm ? 8'h00 : ctrl_demand;
			ctrl_restart <= (temp_alarm && !alarm) ||
				(sel_set != setpoint_out);
			setpoint_out <= sel_set;
		end
	end

	// Sticky events; a read clears, but a new event wins
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq_stat <= '0;
		else
			irq_stat <= (irq_stat & {IRQ_W{!rd_irq}}) | ev;
	end

	property p_halt_cmd;
		@(posedge hclk) disable iff (!hresetn)
		temp_alarm |-> cmd_out == 8'h00;
	endproperty
	a_halt_cmd: assert property (p_halt_cmd)
		else $error("command not closed during alarm");

	property p_lock;
		@(posedge hclk) disable iff (!hresetn)
		lock_in |=> temp_alarm && ctrl_halt;
	endproperty
	a_lock: assert property (p_lock)
		else $error("lock did not halt control");

	property p_aux_to;
		@(posedge hclk) disable iff (!hresetn)
		(wgt_en && aux_cnt == AUX_TIMEOUT_CYC && !wr_aux) |=> temp_alarm;
	endproperty
	a_aux_to: assert property (p_aux_to)
		else $error("bus temperature timeout missed");

	property p_restart;
		@(posedge hclk) disable iff (!hresetn)
		$fell(temp_alarm) |-> ctrl_restart;
	endproperty
	a_restart: assert property (p_restart)
		else $error("no restart when alarm cleared");

	property p_default;
		@(posedge hclk) disable iff (!hresetn)
		(scheme == SCH_SINGLE && !target_rx && !win_q &&
		!ctrl[C_COOL])[*2] |-> setpoint_out == DEF_HEAT;
	endproperty
	a_default: assert property (p_default)
		else $error("heating default not applied");

	property p_window;
		@(posedge hclk) disable iff (!hresetn)
		(win_q && !wr_prot && !ld_prot && !wr_ctrl)[*2] |->
		setpoint_out == (ctrl[C_COOL] ? prot[31:16] : prot[15:0]);
	endproperty
	a_window: assert property (p_window)
		else $error("protection setpoint not applied");

	property p_freeze;
		@(posedge hclk) disable iff (!hresetn)
		win_q && wr_target |=> $stable(target);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("target changed with window open");

	property p_target;
		@(posedge hclk) disable iff (!hresetn)
		wr_target && !win_q |=> target == $past(hwdata[15:0]) &&
		target_rx;
	endproperty
	a_target: assert property (p_target)
		else $error("target write not taken");

	property p_nv;
		@(posedge hclk) disable iff (!hresetn)
		wr_comf && scheme == SCH_REL |=> nv_store &&
		nv_idx == NV_COMF && nv_data[15:0] == comfort;
	endproperty
	a_nv: assert property (p_nv)
		else $error("comfort not stored");

	property p_mode_dflt;
		@(posedge hclk) disable iff (!hresetn)
		!mode_rx |-> mode == TSA_COMFORT;
	endproperty
	a_mode_dflt: assert property (p_mode_dflt)
		else $error("mode not comfort before request");

	property p_relative;
		@(posedge hclk) disable iff (!hresetn)
		(scheme == SCH_REL && act_mode == TSA_STANDBY && comfort_rx &&
		ctrl[C_COOL] && !dp_wr)[*2] |-> setpoint_out ==
		16'(comfort + short_absence_attenuation);
	endproperty
	a_relative: assert property (p_relative)
		else $error("standby not derived from comfort");
endmodule
`default_nettype wire

// ---- test/tsa_sup.sv ----
// Bus supervisor model: AHB-Lite master that writes the objects
`timescale 1ns/1ps
`default_nettype none
module tsa_sup
(
	// Clock and slave answer
	input  wire logic        hclk,
	input  wire logic        hreadyout,
	input  wire logic [31:0] hrdata,
	// Master request
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	// Quiet bus from time zero
	initial
	begin
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// One single word transfer; waits on the slave, never on a count
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'h1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'h1)
			@(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'h1)
			@(posedge hclk);
		q = hrdata;
		// Released data line shows no stale value
		hwdata <= ~d;
	endtask
endmodule
`default_nettype wire

// ---- test/tsa_top_tb.sv ----
// Testbench of the setpoint selection and control alarm block
`timescale 1ns/1ps
`default_nettype none
module tsa_top_tb;
	import tsa_pkg::*;
	// Clock, reset and bus
	logic        hclk = 1'h0;
	logic        hresetn = 1'h0;
	logic        hsel, hwrite, hreadyout, hresp;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, q;
	// Pins and observed outputs
	logic        win = 1'h0;
	logic [63:0] ptemp = 64'h0800;
	logic [63:0] pohm = 64'h4000;
	logic [7:0]  dem = 8'h00, cmd, cyc;
	logic        nvl = 1'h0, nvs, alarm, irq, rst;
	logic [2:0]  nvi = 3'h0;
	logic [31:0] nvd = 32'h0;
	logic [15:0] sp, teff;
	logic        halt, cool;
	logic [2:0]  nvx, nvx_s;
	logic [31:0] nvdo, nvd_s;
	// Model state and counters
	int          error_cnt = 0, comparisons = 0, nv_n = 0, rs_n = 0;
	int          cf, so, old, r = 30;

	always #2 hclk = ~hclk;
	// Count store and restart pulses
	always @(posedge hclk) nv_n += int'(nvs === 1'h1);
	always @(posedge hclk) rs_n += int'(rst === 1'h1);
	// Keep index and word of the latest store pulse
	always @(posedge hclk)
		if (nvs === 1'h1)
		begin
			nvx_s = nvx;
			nvd_s = nvdo;
		end

	tsa_sup i_tsa_sup (.hclk, .hreadyout, .hrdata, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata);
	// Short aux timeout keeps the run brief
	tsa_top #(.AUX_TIMEOUT_CYC(40'h32)) i_tsa_top (.hclk, .hresetn,
		.hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.window_a(win), .window_b(1'h0), .probe_temp(ptemp),
		.probe_ohms(pohm), .ctrl_demand(dem), .cmd_out(cmd),
		.ctrl_halt(halt), .ctrl_restart(rst), .ctrl_cool(cool),
		.setpoint_out(sp), .temp_eff(teff), .cycle_minutes(cyc),
		.temp_alarm(alarm), .irq, .nv_store(nvs), .nv_idx(nvx),
		.nv_data(nvdo), .nv_load(nvl), .nv_load_idx(nvi),
		.nv_load_data(nvd));

	// Xorshift source
	function automatic int xs();
		r ^= r << 13;
		r ^= r >> 17;
		r ^= r << 5;
		return r;
	endfunction

	// Expected working setpoint in relative scheme
	function automatic int esp(int c, int m);
		int o;
		o = (m == 1) ? so : (m == 2) ? int'(DEF_ECON) : 0;
		if (m == 3)
			return c ? int'(DEF_PROT_COOL) : int'(DEF_PROT_HEAT);
		return c ? cf + o : cf - o;
	endfunction

	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		comparisons++;
		if (s !== e)
		begin
			error_cnt++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		i_tsa_sup.xfer(1'h1, a, d, q);
	endtask

	task automatic rd(logic [7:0] a);
		i_tsa_sup.xfer(1'h0, a, 32'h0, q);
	endtask

	task automatic tick(int n);
		repeat (n) @(posedge hclk);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Watchdog well past the expected run length
	initial
	begin
		tick(20000);
		error_cnt++;
		finish_test();
	end

	initial
	begin
		tick(8);
		hresetn <= 1'h1;
		tick(1);
		chk("setpoint", DEF_HEAT, sp);
		chk("cycle", DEF_CYCLE, cyc);
		// Single scheme: target lands and is stored
		cf = xs() & 32'hFFF;
		old = nv_n;
		wr(A_TARGET, cf);
		tick(3);
		chk("target", cf, sp);
		chk("nvstore", old + 1, nv_n);
		chk("nvidx", NV_TARGET, nvx_s);
		chk("nvdata", cf, nvd_s);
		nvl <= 1'h1;
		nvd <= 32'h555;
		tick(1);
		nvl <= 1'h0;
		tick(3);
		chk("restore", 32'h555, sp);
		// Open window forces protection, target frozen
		wr(A_CTRL, 32'h788);
		win <= 1'h1;
		tick(5);
		chk("window", DEF_PROT_HEAT, sp);
		wr(A_TARGET, 32'h777);
		win <= 1'h0;
		tick(6);
		chk("frozen", 32'h555, sp);
		$display("single done");
		// Relative scheme, both directions, every mode code
		wr(A_CTRL, 32'h781);
		cf = 32'h800 + (xs() & 32'h3FF);
		so = 32'h100;
		old = nv_n;
		wr(A_COMF, cf);
		wr(A_STBY, so);
		tick(3);
		chk("comfort", cf, sp);
		chk("nvrel", old + 2, nv_n);
		chk("nvidx", NV_STBY, nvx_s);
		chk("nvdata", so, nvd_s);
		for (int c = 0; c < 2; c++)
			for (int m = 0; m < 4; m++)
			begin
				wr(A_CTRL, 32'h781 | (c << 2));
				wr(A_MODE, m + 1);
				tick(3);
				chk("mode", esp(c, m), sp);
				chk("cool", c, cool);
			end
		// Absolute scheme: supervisor writes a consistent standby value
		wr(A_CTRL, 32'h782);
		wr(A_STBY, cf - so);
		wr(A_MODE, 32'h2);
		tick(3);
		chk("absolute", cf - so, sp);
		$display("relative done");
		// Lock object, then probe channel not thermistor typed
		wr(A_CTRL, 32'h780);
		wr(A_IMASK, 32'h1);
		dem <= 8'(xs() & 32'h3F);
		for (int i = 0; i < 2; i++)
		begin
			rd(A_ISTAT);
			wr(A_CTRL, i ? 32'h700 : 32'hF80);
			tick(3);
			chk("alarm", 1, alarm);
			chk("cmd", 0, cmd);
			chk("halt", 1, halt);
			chk("irq", 1, irq);
			rd(A_ISTAT);
			chk("istat", 1, q[0]);
			chk("irqclr", 0, irq);
			old = rs_n;
			wr(A_CTRL, 32'h780);
			tick(3);
			chk("noalarm", 0, alarm);
			chk("restart", 1, rs_n - old);
			chk("cmdback", dem, cmd);
		end
		$display("alarm done");
		// Weighted mean, then bus temperature goes stale
		wr(A_AUX, 32'h400);
		wr(A_CTRL, 32'h790);
		tick(4);
		chk("teff", 32'h600, teff);
		tick(60);
		chk("auxto", 1, alarm);
		rd(8'h3C);
		chk("unmapped", 0, q);
		chk("hresp", 0, hresp);
		$display("weighting done");
		finish_test();
	end
endmodule
`default_nettype wire
